// ### fsp_cfg.svh
// fsp_cfg.svh: offsets, field positions, reset values and command codes of the flash
// status/protect block. Assumes it is included by bare name after `default_nettype none.
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ------------------------------------------------------------------
// local register port map (byte addresses, one 32-bit word each)
// ------------------------------------------------------------------
`define FSP_REG_STATUS     8'h00
`define FSP_REG_IRQ_STAT   8'h04
`define FSP_REG_IRQ_MASK   8'h08
`define FSP_REG_PROT_LO    8'h0c
`define FSP_REG_PROT_HI    8'h10
`define FSP_REG_OP_CYCLES  8'h14

// ------------------------------------------------------------------
// interrupt status bit positions
// ------------------------------------------------------------------
`define FSP_IRQ_DONE       0
`define FSP_IRQ_NO_LATCH   1
`define FSP_IRQ_PROTECT    2

// ------------------------------------------------------------------
// status byte field positions and write masks
// ------------------------------------------------------------------
`define FSP_S1_BUSY        0
`define FSP_S1_LATCH       1
`define FSP_S1_SEL_LSB     2
`define FSP_S2_QUAD        1
`define FSP_S2_COMPL       6
`define FSP_S3_DUMMY       0
`define FSP_S3_HOLD_RST    7
`define FSP_S1_WMASK       8'hfc
`define FSP_S2_WMASK       8'h43
`define FSP_S2_OTPMASK     8'h38
`define FSP_S3_WMASK       8'he1
`define FSP_SR1_RESET      8'h00
`define FSP_SR2_RESET      8'h00
`define FSP_SR3_RESET      8'h20
`define FSP_OP_CYCLES_DEF  16'h0100

// ------------------------------------------------------------------
// array geometry and command codes
// ------------------------------------------------------------------
`define FSP_ARRAY_END      24'hffffff
`define FSP_ARRAY_SIZE     25'h1000000
`define FSP_BLOCK_UNIT     25'h0040000
`define FSP_SECTOR_UNIT    25'h0001000
`define FSP_MASK_4K        24'h000fff
`define FSP_MASK_32K       24'h007fff
`define FSP_MASK_64K       24'h00ffff
`define FSP_CMD_WREN       8'h06
`define FSP_CMD_WRDI       8'h04
`define FSP_CMD_RDSR1      8'h05
`define FSP_CMD_RDSR2      8'h35
`define FSP_CMD_RDSR3      8'h15
`define FSP_CMD_WRSR1      8'h01
`define FSP_CMD_WRSR2      8'h31
`define FSP_CMD_WRSR3      8'h11
`define FSP_CMD_PP         8'h02
`define FSP_CMD_SE         8'h20
`define FSP_CMD_BE32       8'h52
`define FSP_CMD_BE64       8'hd8
`define FSP_CMD_CE_A       8'h60
`define FSP_CMD_CE_B       8'hc7
`define FSP_BITS_CMD       6'd8
`define FSP_BITS_WRSR      6'd16
`define FSP_BITS_ADDR      6'd32
`define FSP_BITS_SAT       6'd40

`endif

// ### fsp_pkg.sv
// fsp_pkg: types shared by the flash status/protect block.
// Assumes fsp_cfg.svh for all numeric constants.
package fsp_pkg;

  // internal operation that keeps the busy flag up
  typedef enum logic [1:0] {
    FSP_OP_IDLE  = 2'b00,
    FSP_OP_SRW   = 2'b01,
    FSP_OP_PROG  = 2'b10,
    FSP_OP_ERASE = 2'b11
  } fsp_op_t;

  // whole state of the top module
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  sclk_sync;
    logic [1:0]  si_sync;
    logic [5:0]  cnt;
    logic [2:0]  phase;
    logic [7:0]  cmd;
    logic [31:0] shreg;
    logic [23:0] addr;
    logic [7:0]  rdbuf;
    logic        so;
    logic        so_drive;
    logic [7:0]  sr1;
    logic [7:0]  sr2;
    logic [7:0]  sr3;
    logic        write_enable_latch;
    logic [15:0] busy_cnt;
    fsp_op_t     op;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [15:0] op_cycles;
    logic [31:0] rdata;
  } fsp_state_t;

endpackage : fsp_pkg

// ### fsp_range_decode.sv
// fsp_range_decode: turns the five protect-select bits and the complement bit into an
// inclusive protected address range. Pure combinational; the caller registers nothing.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module fsp_range_decode
  import fsp_pkg::*;
(
  input  wire logic [4:0]  sel,
  input  wire logic        compl,
  output logic             none,
  output logic [23:0]      lo,
  output logic [23:0]      hi
);

  // ------------------------------------------------------------------
  // base region as for complement clear, then flipped when complement set
  // ------------------------------------------------------------------
  always_comb begin
    logic [2:0]  k;
    logic [2:0]  sh;
    logic [24:0] size;
    logic [23:0] blo;
    logic [23:0] bhi;
    logic        b_none;
    logic        b_all;
    k      = sel[2:0];            // upper two bits matter only for shape
    sh     = (k == 3'h0) ? 3'h0 : k - 3'h1;
    b_none = (k == 3'h0);
    b_all  = (k == 3'h7);
    size   = `FSP_BLOCK_UNIT;
    blo    = 24'h000000;
    bhi    = `FSP_ARRAY_END;
    // small top/bottom regions saturate at 32KB for codes 10x and 110
    if (sel[4]) begin
      size = `FSP_SECTOR_UNIT << ((k >= 3'h4) ? 3'h3 : sh);
    end else begin
      size = `FSP_BLOCK_UNIT << sh;
    end
    if (sel[3]) begin
      blo = 24'h000000;
      bhi = 24'(size - 25'h1);
    end else begin
      blo = 24'(`FSP_ARRAY_SIZE - size);
      bhi = `FSP_ARRAY_END;
    end
    none = b_none;
    lo   = blo;
    hi   = bhi;
    if (!compl) begin
      if (b_all) begin
        lo = 24'h000000;
        hi = `FSP_ARRAY_END;
      end
    end else begin
      none = b_all;
      if (b_none) begin
        lo = 24'h000000;
        hi = `FSP_ARRAY_END;
      end else if (blo == 24'h000000) begin
        lo = bhi + 24'h1;
        hi = `FSP_ARRAY_END;
      end else begin
        lo = 24'h000000;
        hi = blo - 24'h1;
      end
    end
  end

endmodule : fsp_range_decode
`default_nettype wire

// ### fsp_top.sv
// fsp_top: status bytes, write-enable latch, busy flag and array protection of a serial
// flash, with a sampled serial command link and a local register port with interrupt.
// Assumes clk at 100 MHz, link clock well below clk/4, and link pins asynchronous to clk.
// Behaviour
// - complement lower regions for codes 001..110
// - complement upper regions from 256KB to 8MB
// - complement: 000 protects all, 111 none
// - complement: all except small top region
// - complement: all except small bottom region
// - bottom 16KB and 32KB regions, complement clear
// - first status byte field layout
// - second status byte field layout
// - third status byte field layout
// - busy flag high during internal operation
// - busy flag low when nothing runs
// - writes refused while latch is clear
// - program/erase into protected range rejected
// - shared pin mode from quad and select
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module fsp_top
  import fsp_pkg::*;
#(
  parameter logic [15:0] OP_CYCLES_DEFAULT = `FSP_OP_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe_n,
  output logic             write_in_progress,
  output logic             pin_hold_mode,
  output logic             pin_reset_mode,
  output logic             pin_data_mode
);

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  if (OP_CYCLES_DEFAULT == 16'h0000) begin : g_chk
    $error("OP_CYCLES_DEFAULT must be nonzero");
  end

  fsp_state_t s;
  fsp_state_t next_s;

  logic        rise;
  logic        fall;
  logic        cs_low;
  logic        cs_end;
  logic        prot_none;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;
  logic [7:0]  view1;
  logic [7:0]  view2;
  logic [7:0]  view3;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // true when [addr & ~m, addr | m] touches the protected range
  function automatic logic hits(input logic [23:0] a, input logic [23:0] m,
                                input logic [23:0] l, input logic [23:0] h,
                                input logic n);
    hits = !n && ((a & ~m) <= h) && ((a | m) >= l);
  endfunction : hits

  function automatic logic is_rdsr(input logic [7:0] c);
    is_rdsr = (c == `FSP_CMD_RDSR1) || (c == `FSP_CMD_RDSR2) || (c == `FSP_CMD_RDSR3);
  endfunction : is_rdsr

  // ------------------------------------------------------------------
  // link edges from the second and third sync stages only
  // ------------------------------------------------------------------
  assign rise   = s.sclk_sync[1] & ~s.sclk_sync[2];
  assign fall   = ~s.sclk_sync[1] & s.sclk_sync[2];
  assign cs_low = ~s.cs_sync[1];
  assign cs_end = s.cs_sync[1] & ~s.cs_sync[2];

  // protected range follows the stored bits every cycle
  fsp_range_decode u_dec (
    .sel  (s.sr1[6:2]),
    .compl(s.sr2[`FSP_S2_COMPL]),
    .none (prot_none),
    .lo   (prot_lo),
    .hi   (prot_hi)
  );

  // status views; volatile bits composed live, reserved read zero
  assign view1 = {s.sr1[7:2], s.write_enable_latch, (s.busy_cnt != 16'h0000)};
  assign view2 = {1'b0, s.sr2[6:3], 1'b0, s.sr2[1:0]};
  assign view3 = {s.sr3[7:5], 4'h0, s.sr3[0]};

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0]  b;
    logic [2:0]  ev;
    logic [2:0]  clr;
    logic [23:0] m;
    logic        ok_len;
    logic        is_mem;
    fsp_op_t     kind;
    next_s = s;
    b      = 8'h00;
    ev     = 3'h0;
    clr    = 3'h0;
    m      = 24'h000000;
    ok_len = 1'b0;
    is_mem = 1'b0;
    kind   = FSP_OP_IDLE;
    next_s.cs_sync   = {s.cs_sync[1:0], cs_n};
    next_s.sclk_sync = {s.sclk_sync[1:0], sclk};
    next_s.si_sync   = {s.si_sync[0], si};

    // shift in on link rising edge; frame state cleared while deselected
    if (!cs_low) begin
      next_s.cnt      = 6'd0;
      next_s.phase    = 3'h0;
      next_s.so_drive = 1'b0;
    end else if (rise) begin
      next_s.shreg = {s.shreg[30:0], s.si_sync[1]};
      next_s.phase = s.phase + 3'h1;
      if (s.cnt < `FSP_BITS_SAT) begin
        next_s.cnt = s.cnt + 6'd1;
      end
      if (s.cnt == `FSP_BITS_CMD - 6'd1) begin
        next_s.cmd = {s.shreg[6:0], s.si_sync[1]};
      end
      if (s.cnt == `FSP_BITS_ADDR - 6'd1) begin
        next_s.addr = {s.shreg[22:0], s.si_sync[1]};
      end
    end

    // status read-out on falling edge; a fresh byte each 8 bits keeps busy live
    if (cs_low && fall && is_rdsr(s.cmd) && (s.cnt >= `FSP_BITS_CMD)) begin
      next_s.so_drive = 1'b1;
      if (s.phase == 3'h0) begin
        unique case (s.cmd)
          `FSP_CMD_RDSR2: b = view2;
          `FSP_CMD_RDSR3: b = view3;
          default:        b = view1;
        endcase
        next_s.so    = b[7];
        next_s.rdbuf = {b[6:0], 1'b0};
      end else begin
        next_s.so    = s.rdbuf[7];
        next_s.rdbuf = {s.rdbuf[6:0], 1'b0};
      end
    end

    // internal operation countdown
    if (s.busy_cnt != 16'h0000) begin
      next_s.busy_cnt = s.busy_cnt - 16'h0001;
      if (s.busy_cnt == 16'h0001) begin
        next_s.op          = FSP_OP_IDLE;
        ev[`FSP_IRQ_DONE]  = 1'b1;
      end
    end

    // commands act at deselect, only on a byte boundary and when idle
    if (cs_end && (s.phase == 3'h0) && (s.cnt >= `FSP_BITS_CMD)
        && (s.busy_cnt == 16'h0000)) begin
      case (s.cmd)
        `FSP_CMD_WREN: next_s.write_enable_latch = 1'b1;
        `FSP_CMD_WRDI: next_s.write_enable_latch = 1'b0;
        `FSP_CMD_WRSR1, `FSP_CMD_WRSR2, `FSP_CMD_WRSR3: begin
          if (s.cnt == `FSP_BITS_WRSR) begin
            if (!s.write_enable_latch) begin
              ev[`FSP_IRQ_NO_LATCH] = 1'b1;
            end else begin
              if (s.cmd == `FSP_CMD_WRSR1) begin
                next_s.sr1 = (s.shreg[7:0] & `FSP_S1_WMASK);
              end else if (s.cmd == `FSP_CMD_WRSR2) begin
                // lock bits only ever go from 0 to 1
                next_s.sr2 = (s.shreg[7:0] & `FSP_S2_WMASK)
                           | ((s.sr2 | s.shreg[7:0]) & `FSP_S2_OTPMASK);
              end else begin
                next_s.sr3 = (s.shreg[7:0] & `FSP_S3_WMASK);
              end
              next_s.write_enable_latch = 1'b0;
              next_s.op       = FSP_OP_SRW;
              next_s.busy_cnt = s.op_cycles;
            end
          end
        end
        `FSP_CMD_PP: begin
          is_mem = 1'b1;
          ok_len = (s.cnt == `FSP_BITS_SAT);
          m      = 24'h000000;
          kind   = FSP_OP_PROG;
        end
        `FSP_CMD_SE: begin
          is_mem = 1'b1;
          ok_len = (s.cnt == `FSP_BITS_ADDR);
          m      = `FSP_MASK_4K;
          kind   = FSP_OP_ERASE;
        end
        `FSP_CMD_BE32: begin
          is_mem = 1'b1;
          ok_len = (s.cnt == `FSP_BITS_ADDR);
          m      = `FSP_MASK_32K;
          kind   = FSP_OP_ERASE;
        end
        `FSP_CMD_BE64: begin
          is_mem = 1'b1;
          ok_len = (s.cnt == `FSP_BITS_ADDR);
          m      = `FSP_MASK_64K;
          kind   = FSP_OP_ERASE;
        end
        `FSP_CMD_CE_A, `FSP_CMD_CE_B: begin
          is_mem = 1'b1;
          ok_len = (s.cnt == `FSP_BITS_CMD);
          m      = `FSP_ARRAY_END;
          kind   = FSP_OP_ERASE;
        end
        default: ;
      endcase
      if (is_mem && ok_len) begin
        if (!s.write_enable_latch) begin
          ev[`FSP_IRQ_NO_LATCH] = 1'b1;
        end else if (hits(s.addr, m, prot_lo, prot_hi, prot_none)) begin
          ev[`FSP_IRQ_PROTECT] = 1'b1;
        end else begin
          next_s.write_enable_latch = 1'b0;
          next_s.op       = kind;
          next_s.busy_cnt = s.op_cycles;
        end
      end
    end

    // register port; a new event beats a same-cycle clear
    if (reg_wr) begin
      unique case (reg_addr)
        `FSP_REG_IRQ_STAT:  clr = reg_wdata[2:0];
        `FSP_REG_IRQ_MASK:  next_s.irq_mask = reg_wdata[2:0];
        `FSP_REG_OP_CYCLES: begin
          if (reg_wdata[15:0] != 16'h0000) begin
            next_s.op_cycles = reg_wdata[15:0];
          end
        end
        default: ;
      endcase
    end
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    next_s.rdata    = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `FSP_REG_STATUS:    next_s.rdata = {8'h00, view3, view2, view1};
        `FSP_REG_IRQ_STAT:  next_s.rdata = {29'h0, s.irq_stat};
        `FSP_REG_IRQ_MASK:  next_s.rdata = {29'h0, s.irq_mask};
        `FSP_REG_PROT_LO:   next_s.rdata = {7'h00, prot_none, prot_lo};
        `FSP_REG_PROT_HI:   next_s.rdata = {8'h00, prot_hi};
        `FSP_REG_OP_CYCLES: next_s.rdata = {16'h0000, s.op_cycles};
        default:            next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register; nonvolatile bits only see the power-up reset here
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s           <= '0;
      s.cs_sync   <= 3'h7;
      s.sr1       <= `FSP_SR1_RESET;
      s.sr2       <= `FSP_SR2_RESET;
      s.sr3       <= `FSP_SR3_RESET;
      s.op        <= FSP_OP_IDLE;
      s.op_cycles <= OP_CYCLES_DEFAULT;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_rdata      = s.rdata;
  assign irq            = |(s.irq_stat & s.irq_mask);
  assign so             = s.so;
  assign so_oe_n        = ~(s.so_drive & cs_low);
  assign write_in_progress = (s.busy_cnt != 16'h0000);
  // quad mode takes the shared pin as data, else select picks hold or reset
  assign pin_data_mode  = s.sr2[`FSP_S2_QUAD];
  assign pin_hold_mode  = ~s.sr2[`FSP_S2_QUAD] & ~s.sr3[`FSP_S3_HOLD_RST];
  assign pin_reset_mode = ~s.sr2[`FSP_S2_QUAD] & s.sr3[`FSP_S3_HOLD_RST];

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  compl_lower_a: assert property (s.sr2[6] && s.sr1[6:2] == 5'b00001
    |-> !prot_none && prot_lo == 24'h000000 && prot_hi == 24'hfbffff)
    else $error("complement lower region wrong");
  compl_upper_a: assert property (s.sr2[6] && s.sr1[6:2] == 5'b01110
    |-> prot_lo == 24'h800000 && prot_hi == 24'hffffff)
    else $error("complement upper region wrong");
  compl_all_none_a: assert property (s.sr2[6] && s.sr1[4:2] != 3'h1 && s.sr1[4:2] != 3'h2
    |-> (s.sr1[4:2] == 3'h0) == (!prot_none && prot_lo == 24'h0 && prot_hi == 24'hffffff)
        && (s.sr1[4:2] == 3'h7) == prot_none)
    else $error("complement all or none wrong");
  compl_top_a: assert property (s.sr2[6] && s.sr1[6:2] == 5'b10101
    |-> prot_lo == 24'h000000 && prot_hi == 24'hff7fff)
    else $error("complement top exclusion wrong");
  compl_bottom_a: assert property (s.sr2[6] && s.sr1[6:2] == 5'b11001
    |-> prot_lo == 24'h001000 && prot_hi == 24'hffffff)
    else $error("complement bottom exclusion wrong");
  bottom_region_a: assert property (!s.sr2[6] && s.sr1[6:2] == 5'b11011
    |-> prot_lo == 24'h000000 && prot_hi == 24'h003fff)
    else $error("bottom 16KB region wrong");
  status_read_a: assert property (reg_rd && reg_addr == `FSP_REG_STATUS
    |=> reg_rdata[1:0] == {$past(s.write_enable_latch), $past(write_in_progress)}
        && reg_rdata[20:17] == 4'h0)
    else $error("status read layout wrong");
  susp_zero_a: assert property (reg_rd && reg_addr == `FSP_REG_STATUS
    |=> reg_rdata[15] == 1'b0 && reg_rdata[10] == 1'b0)
    else $error("suspend bits not zero");
  otp_hold_a: assert property ($past(s.sr2[5:3]) != 3'h0
    |-> (s.sr2[5:3] & $past(s.sr2[5:3])) == $past(s.sr2[5:3]))
    else $error("lock bit cleared");
  busy_high_a: assert property (s.op != FSP_OP_IDLE |-> write_in_progress)
    else $error("busy flag low during operation");
  busy_drop_a: assert property (s.busy_cnt == 16'h0001
    |=> !write_in_progress && s.op == FSP_OP_IDLE)
    else $error("busy flag did not drop");
  no_latch_a: assert property (!s.write_enable_latch && !write_in_progress
    |=> $stable(s.sr1) && !write_in_progress)
    else $error("write accepted without latch");
  protect_a: assert property (s.irq_stat[`FSP_IRQ_PROTECT] == 1'b0 ##1
    s.irq_stat[`FSP_IRQ_PROTECT] |-> $past(s.op) == s.op || s.op == FSP_OP_IDLE)
    else $error("protected command started");
  pin_mode_a: assert property ($onehot({pin_data_mode, pin_hold_mode, pin_reset_mode}))
    else $error("shared pin mode not one-hot");

endmodule : fsp_top
`default_nettype wire

// ### fsp_spi_host.sv
// fsp_spi_host: behavioural serial host that shifts command frames into the block.
// Assumes mode 0 framing and a 160 ns link clock that only runs inside frames.
`timescale 1ns/1ps
`default_nettype none

module fsp_spi_host (
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  logic [7:0] rx;

  // idle: deselected, clock parked low
  initial begin
    rx   = 8'h00;
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // shift n bits msb first; data flips after the frame so nothing stale looks valid
  task automatic xfer(input logic [39:0] f, input int n);
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      si = f[39-i];
      #80 sclk = 1'b1;
      // sample on the rise; an undriven line reads high as if pulled up
      rx = {rx[6:0], (so_oe_n ? 1'b1 : so)};
      #80 sclk = 1'b0;
    end
    #80 si = ~si;
    cs_n = 1'b1;
    #400;
  endtask : xfer
endmodule : fsp_spi_host

`default_nettype wire

// ### fsp_top_tb_top.sv
// fsp_top_tb_top: register and link sequences with expected values for fsp_top.
// Assumes fsp_spi_host as the link partner and a busy length of 4 clk.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"

module fsp_top_tb_top
  import fsp_pkg::*;
;
  logic        clk, arst_n, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic        irq, cs_n, sclk, si, so, so_oe_n, busy, hm, rm, dm;
  int          n_mismatch, n_tests, n;
  // {cmp,sel} cases with expected range; lo bit 24 is the empty flag
  logic [5:0]  cs[13] = '{6'h21, 6'h26, 6'h29, 6'h2e, 6'h38, 6'h27, 6'h31, 6'h34,
                          6'h39, 6'h3d, 6'h1b, 6'h1d, 6'h1e};
  logic [24:0] lo[13] = '{0, 0, 25'h40000, 25'h800000, 0, 25'h1000000, 0, 0,
                          25'h1000, 25'h8000, 0, 0, 0};
  logic [23:0] hi[13] = '{24'hfbffff, 24'h7fffff, 24'hffffff, 24'hffffff, 24'hffffff, 0,
                          24'hffefff, 24'hff7fff, 24'hffffff, 24'hffffff, 24'h3fff,
                          24'h7fff, 24'h7fff};

  fsp_top #(.OP_CYCLES_DEFAULT(16'h0004)) DUT (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
    .so_oe_n(so_oe_n), .write_in_progress(busy), .pin_hold_mode(hm), .pin_reset_mode(rm),
    .pin_data_mode(dm));
  fsp_spi_host host (.so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sclk(sclk), .si(si));

  // ----------------------------------------------------------------
  // clock, reset and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;  // outputs launched by the write edge are settled for the caller
  endtask : wr

  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rd

  // frame, then wait out the busy flag under a bound
  task automatic lk(input logic [39:0] f, input int nb);
    host.xfer(f, nb);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) n_mismatch++;  // a busy flag that never drops is a failure
  endtask : lk

  task automatic wrsr(input logic [7:0] c, input logic [7:0] d);
    lk({`FSP_CMD_WREN, 32'h0}, 8);
    lk({c, d, 24'h0}, 16);
  endtask : wrsr

  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // watchdog well beyond the expected two hundred microseconds
  initial begin
    #500_000;
    n_mismatch++;
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(`FSP_REG_STATUS, '1, 32'h00200000);
    chk({hm, rm, dm}, 3'b100);
    rd(8'h40, '1, 32'h0);
    wr(`FSP_REG_IRQ_MASK, 32'h7);
    lk({`FSP_CMD_WREN, 32'h0}, 8);
    rd(`FSP_REG_STATUS, '1, 32'h00200002);
    // busy must last exactly the configured length
    // count while the frame runs: the busy window ends before the frame tail does
    n = 0;
    fork
      host.xfer({`FSP_CMD_WRSR1, 8'h1c, 24'h0}, 16);
      repeat (400) begin
        @(posedge clk);
        #1 if (busy === 1'b1) n++;
      end
    join
    chk(n, 4);
    rd(`FSP_REG_STATUS, '1, 32'h0020001c);
    lk({`FSP_CMD_RDSR1, 32'h0}, 16);
    chk(host.rx, 32'h1c);
    wr(`FSP_REG_IRQ_STAT, 32'h7);
    lk({`FSP_CMD_WRSR1, 8'h00, 24'h0}, 16);
    rd(`FSP_REG_IRQ_STAT, '1, 32'h2);
    rd(`FSP_REG_STATUS, '1, 32'h0020001c);
    chk(irq, 1'b1);
    wr(`FSP_REG_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    wr(`FSP_REG_IRQ_MASK, 32'h7);
    wr(`FSP_REG_IRQ_STAT, 32'h2);
    chk(irq, 1'b0);
    // decode table, complement set first then clear
    for (int k = 0; k < 13; k++) begin
      wrsr(`FSP_CMD_WRSR2, {1'b0, cs[k][5], 6'h0});
      wrsr(`FSP_CMD_WRSR1, {1'b0, cs[k][4:0], 2'b00});
      if (lo[k][24])
        rd(`FSP_REG_PROT_LO, 32'h01000000, 32'h01000000);
      else begin
        rd(`FSP_REG_PROT_LO, 32'h01ffffff, {7'h0, lo[k]});
        rd(`FSP_REG_PROT_HI, 32'h00ffffff, {8'h0, hi[k]});
      end
    end
    // erase into and just past the protected bottom 32KB
    wr(`FSP_REG_IRQ_STAT, 32'h7);
    lk({`FSP_CMD_WREN, 32'h0}, 8);
    lk({`FSP_CMD_SE, 24'h007000, 8'h0}, 32);
    rd(`FSP_REG_IRQ_STAT, '1, 32'h4);
    wr(`FSP_REG_IRQ_STAT, 32'h7);
    lk({`FSP_CMD_SE, 24'h008000, 8'h0}, 32);
    rd(`FSP_REG_IRQ_STAT, '1, 32'h1);
    // upper bytes: reserved and suspend bits stay 0, pin mode follows
    wrsr(`FSP_CMD_WRSR3, 8'hff);
    chk({hm, rm, dm}, 3'b010);
    wrsr(`FSP_CMD_WRSR2, 8'hff);
    chk({hm, rm, dm}, 3'b001);
    rd(`FSP_REG_STATUS, '1, 32'h00e17b78);
    lk({`FSP_CMD_RDSR2, 32'h0}, 16);
    chk(host.rx, 32'h7b);
    // complement now guards 32KB upward: chip erase and a block there refused
    wr(`FSP_REG_IRQ_STAT, 32'h7);
    lk({`FSP_CMD_WREN, 32'h0}, 8);
    lk({`FSP_CMD_CE_A, 32'h0}, 8);
    lk({`FSP_CMD_BE64, 24'h010000, 8'h0}, 32);
    rd(`FSP_REG_IRQ_STAT, '1, 32'h4);
    lk({`FSP_CMD_PP, 24'h0000f0, 8'ha5}, 40);
    rd(`FSP_REG_IRQ_STAT, '1, 32'h5);
    wr(`FSP_REG_IRQ_STAT, 32'h7);
    lk({`FSP_CMD_WREN, 32'h0}, 8);
    lk({`FSP_CMD_BE32, 24'h004000, 8'h0}, 32);
    rd(`FSP_REG_IRQ_STAT, '1, 32'h1);
    lk({`FSP_CMD_WREN, 32'h0}, 8);
    lk({`FSP_CMD_WRDI, 32'h0}, 8);
    lk({`FSP_CMD_WRSR1, 8'h00, 24'h0}, 16);
    rd(`FSP_REG_STATUS, '1, 32'h00e17b78);
    conclude();
  end
endmodule : fsp_top_tb_top

`default_nettype wire
